// ### verification/dual_adc_serial_mode_select_props.sv
`timescale 1ns/1ns
// ==========
// port relations of the bus and of the pin release
module dual_adc_serial_mode_select_props (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] wb_adr_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [1:0] convert_strobe_i,
    input wire [1:0] result_serial_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd = wb_ack_o && !wb_we_i;
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    a_unmapped_zero: assert property (rd && wb_adr_i[7:4] != 4'h0 |-> wb_dat_o == 32'h0) else $error("unmapped");
    a_level_width: assert property (rd && wb_adr_i < 8'h08 |-> wb_dat_o[31:18] == 14'h0) else $error("level");
    a_status_spare: assert property (rd && wb_adr_i == 8'h08 |->
        {wb_dat_o[31:16], wb_dat_o[15:12], wb_dat_o[7:4]} == 24'h0) else $error("status spare");
    // the pin must stay released from 8 to 15 cycles after the strobe rises, early in the 125-cycle internal conversion
    a_conv_quiet0: assert property ($rose(convert_strobe_i[0]) |->
        ##8 result_serial_oe_n_o[0] [*8]) else $error("ch0 driven");
    a_conv_quiet1: assert property ($rose(convert_strobe_i[1]) |->
        ##8 result_serial_oe_n_o[1] [*8]) else $error("ch1 driven");
    c_drive0: cover property ($fell(result_serial_oe_n_o[0]));
    c_start1: cover property ($rose(convert_strobe_i[1]));
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind dual_adc_serial_mode_select dual_adc_serial_mode_select_props u_props (.clk_i, .rst_i, .wb_adr_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .convert_strobe_i, .result_serial_oe_n_o);

// ### verification/dual_adc_serial_mode_select_tb.sv
`timescale 1ns/1ns
`include "dual_adc_serial_regs.vh"
module dual_adc_serial_mode_select_tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [7:0] adr = 8'h00;
    reg [31:0] dat = 32'h0;
    reg we = 1'b0;
    reg cyc = 1'b0;
    wire [31:0] rdat;
    wire ack;
    wire [1:0] str, sck, sel, sdo, oe_n;
    integer mismatches = 0;
    integer n_tests = 0;
    logic [31:0] q_bus[$];
    logic [17:0] q_word[$];
    always #2 clk_i = ~clk_i;
    dual_adc_serial_mode_select u_dual_adc_serial_mode_select (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_ack_o(ack), .convert_strobe_i(str), .serial_shift_clock_i(sck), .chain_select_input_i(sel),
        .result_serial_output_o(sdo), .result_serial_oe_n_o(oe_n));
    host_link u_host0 (.clk_i(clk_i), .sdo_i(sdo[0]), .oe_n_i(oe_n[0]), .strobe_o(str[0]), .sck_o(sck[0]),
        .sel_o(sel[0]));
    host_link u_host1 (.clk_i(clk_i), .sdo_i(sdo[1]), .oe_n_i(oe_n[1]), .strobe_o(str[1]), .sck_o(sck[1]),
        .sel_o(sel[1]));
    task stop_test;
        begin
            $display("tests %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task tally(input ok, input [8*8:1] what);
        begin
            n_tests++;
            if (!ok) begin
                mismatches++;
                $display("ERROR %0t %0s mismatch", $time, what);
            end
        end
    endtask
    task cmp_bus(input [31:0] e, input [31:0] g);
        tally(g === e, "bus");
    endtask
    task cmp_word(input [17:0] e, input [17:0] g);
        tally(g === e, "serial");
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        integer i;
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
            if (i == 20) begin
                mismatches++;
                $display("ERROR %0t bus timeout", $time);
                stop_test;
            end else begin
                cyc <= 1'b0;
            end
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            q_bus.push_back(e);
            wb(1'b0, a, 32'h0);
        end
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && !we) cmp_bus(q_bus.pop_front(), rdat);
        if (u_host0.done | u_host1.done) cmp_word(q_word.pop_front(), u_host0.done ? u_host0.word : u_host1.word);
    end
    function [15:0] code(input [17:0] lv);
        code = lv[17] ? `CODE_ZERO : lv[16] ? `CODE_FULL : lv[15:0];
    endfunction
    initial begin
        integer i, m;
        logic [17:0] lv;
        logic [7:0] a;
        logic [7:0] sb;
        void'($urandom(32'hdad6));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(`LEVEL0_ADDR, 32'h0);
        rd(`LEVEL1_ADDR, 32'h0);
        rd(`STATUS_ADDR, 32'h0);
        rd(8'h10, 32'h0);
        for (i = 0; i < 12; i++) begin
            m = i % 6;
            a = m == 5 ? `LEVEL1_ADDR : `LEVEL0_ADDR;
            lv = (i + i / 6) % 3 == 1 ? 18'h10000 : (i + i / 6) % 3 == 2 ? 18'h30000 : {2'b00, 16'($urandom)};
            wb(1'b1, a, {14'h0, lv});
            rd(a, {14'h0, lv});
            q_word.push_back(m > 3 ? {code(lv), 2'b01} : {1'b0, code(lv), 1'b1});
            case (m)
                0: u_host0.frame(2'd1, 1'b0, 1'b1, 1'b0, 1'b1, 17);
                1: u_host0.frame(2'd1, 1'b0, 1'b0, 1'b0, 1'b1, 18);
                2: u_host0.frame(i > 6 ? 2'd3 : 2'd1, 1'b0, 1'b1, 1'b1, 1'b0, i > 6 ? 18 : 17);
                3: u_host0.frame(2'd0, 1'b1, 1'b1, 1'b1, 1'b0, 18);
                4: u_host0.frame(2'd0, 1'b0, 1'b1, 1'b1, 1'b0, 18);
                default: u_host1.frame(2'd2, 1'b0, 1'b1, 1'b1, 1'b0, 18);
            endcase
            // per channel: readout bit, chain bit and busy bit; converting must be clear again
            sb = m > 2 ? (m == 3 ? 8'h0e : 8'h06) : (m == 1 || i == 8 ? 8'h08 : 8'h00);
            rd(`STATUS_ADDR, {16'h0000, (i > 4 ? 8'h06 : 8'h00), sb});
        end
        stop_test;
    end
endmodule

// ### verification/host_link.sv
`timescale 1ns/1ns
// ==========
// serial master for one channel; a released data pin reads as the pull-up
module host_link (
    input wire clk_i,
    input wire sdo_i,
    input wire oe_n_i,
    output reg strobe_o = 1'b0,
    output reg sck_o = 1'b0,
    output reg sel_o = 1'b1
);
    reg done = 1'b0;
    reg [17:0] word = 18'h0;
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    // s0: 0 low, 1 high, 2 tied to the strobe, 3 high with the strobe dropped during conversion
    task frame(input [1:0] s0, input k0, input sc, input sr, input tr, input integer n);
        integer i;
        begin
            tick(1);
            strobe_o <= 1'b0;
            sel_o <= s0[0];
            sck_o <= k0;
            word <= 18'h0;
            tick(8);
            strobe_o <= 1'b1;
            if (s0[1]) sel_o <= 1'b1;
            tick(6);
            sck_o <= 1'b0;
            if (s0 == 2'd3) strobe_o <= 1'b0;
            sel_o <= sc;
            tick(140);
            sel_o <= sr;
            strobe_o <= tr;
            tick(6);
            for (i = 0; i < n; i++) begin
                word <= {word[16:0], oe_n_i ? 1'b1 : sdo_i};
                sck_o <= 1'b1;
                tick(20);
                sck_o <= 1'b0;
                tick(20);
            end
            done <= 1'b1;
            sel_o <= 1'b1;
            tick(1);
            done <= 1'b0;
        end
    endtask
endmodule

// ### verilog/dual_adc_serial_mode_select.v
`timescale 1ns/1ns
`include "dual_adc_serial_regs.vh"
module dual_adc_serial_mode_select (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire [1:0] convert_strobe_i,
    input wire [1:0] serial_shift_clock_i,
    input wire [1:0] chain_select_input_i,
    output wire [1:0] result_serial_output_o,
    output wire [1:0] result_serial_oe_n_o
);

localparam ST_ACQ = 3'b001;
localparam ST_CONV = 3'b010;
localparam ST_READ = 3'b100;
localparam integer CONV_LOAD_FULL = `CONV_CYCLES - 1;
localparam [7:0] CONV_LOAD = CONV_LOAD_FULL[7:0];

// =====================================================
// bus slave: level registers stand in for the analog inputs
reg [17:0] level0;
reg [17:0] level1;
wire [31:0] status;
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        level0 <= `LEVEL_RESET;
        level1 <= `LEVEL_RESET;
    end else begin
        wb_ack_o <= wb_req;
        wb_dat_o <= 32'h00000000;
        if (wb_req & wb_we_i) begin
            if (wb_adr_i == `LEVEL0_ADDR) begin
                if (wb_sel_i[0]) level0[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) level0[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) level0[17:16] <= wb_dat_i[17:16];
            end
            if (wb_adr_i == `LEVEL1_ADDR) begin
                if (wb_sel_i[0]) level1[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) level1[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) level1[17:16] <= wb_dat_i[17:16];
            end
        end else if (wb_req) begin
            case (wb_adr_i)
                `LEVEL0_ADDR: wb_dat_o <= {14'h0000, level0};
                `LEVEL1_ADDR: wb_dat_o <= {14'h0000, level1};
                `STATUS_ADDR: wb_dat_o <= status;
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end
end

assign status[31:16] = 16'h0000;

// =====================================================
// one converter per channel, nothing shared between them
genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : conv
        reg [2:0] cnv_sync;
        reg [2:0] sck_sync;
        reg [2:0] sdi_sync;
        reg cnv_f;
        reg sck_f;
        reg sdi_f;
        reg [2:0] state;
        reg [7:0] cnt;
        reg [16:0] sh;
        reg [4:0] bits;
        reg chain;
        reg busy;
        reg started;
        reg drive;
        reg oe_n;
        wire [17:0] lvl = (ch == 0) ? level0 : level1;
        wire [15:0] code;
        wire next_cnv;
        wire next_sck;
        wire next_sdi;
        wire cnv_rise;
        wire sck_fall;
        wire sel;

        // a level counts only once the second and third stages agree
        assign next_cnv = (cnv_sync[1] == cnv_sync[2]) ? cnv_sync[2] : cnv_f;
        assign next_sck = (sck_sync[1] == sck_sync[2]) ? sck_sync[2] : sck_f;
        assign next_sdi = (sdi_sync[1] == sdi_sync[2]) ? sdi_sync[2] : sdi_f;
        assign cnv_rise = next_cnv & ~cnv_f;
        assign sck_fall = ~next_sck & sck_f;
        // readout select: strobe low in 3-wire, chain/select low in 4-wire
        assign sel = ~next_cnv | ~next_sdi;
        // bit 17 marks below zero, bit 16 above full scale
        assign code = lvl[17] ? `CODE_ZERO : (lvl[16] ? `CODE_FULL : lvl[15:0]);

        always @(posedge clk_i) begin
            if (rst_i) begin
                cnv_sync <= 3'b000;
                sck_sync <= 3'b000;
                sdi_sync <= 3'b000;
                cnv_f <= 1'b0;
                sck_f <= 1'b0;
                sdi_f <= 1'b0;
                state <= ST_ACQ;
                cnt <= 8'h00;
                sh <= 17'h00000;
                bits <= 5'h00;
                chain <= 1'b0;
                busy <= 1'b0;
                started <= 1'b0;
                drive <= 1'b0;
                oe_n <= 1'b1;
            end else begin
                // enable pin comes from its own flop, one cycle behind drive
                oe_n <= ~drive;
                cnv_sync <= {cnv_sync[1:0], convert_strobe_i[ch]};
                sck_sync <= {sck_sync[1:0], serial_shift_clock_i[ch]};
                sdi_sync <= {sdi_sync[1:0], chain_select_input_i[ch]};
                cnv_f <= next_cnv;
                sck_f <= next_sck;
                sdi_f <= next_sdi;
                case (state)
                    ST_ACQ, ST_READ: begin
                        if (cnv_rise) begin
                            // sdi_f still holds the level from before the edge, so a
                            // chain/select pin tied to the strobe reads low here
                            chain <= ~sdi_f;
                            busy <= ~sdi_f & sck_f;
                            cnt <= CONV_LOAD;
                            drive <= 1'b0;
                            started <= 1'b0;
                            state <= ST_CONV;
                        end else if (state == ST_READ && chain) begin
                            // a busy start bit keeps the pin driven even with the strobe high
                            drive <= busy | ~next_cnv;
                            if (sck_fall & drive) begin
                                sh <= {sh[15:0], sdi_f};
                            end
                        end else if (state == ST_READ) begin
                            if (started & ~sel) begin
                                drive <= 1'b0;
                                state <= ST_ACQ;
                            end else if (sel) begin
                                drive <= 1'b1;
                                started <= 1'b1;
                                if (sck_fall & started) begin
                                    sh <= {sh[15:0], 1'b0};
                                    bits <= bits - 5'h01;
                                    if (bits == 5'h01) begin
                                        drive <= 1'b0;
                                        state <= ST_ACQ;
                                    end
                                end
                            end
                        end
                    end
                    ST_CONV: begin
                        // internal count, the serial clock plays no part
                        cnt <= cnt - 8'h01;
                        if (cnt == 8'h00) begin
                            // conversion over: on to the readout state
                            state <= ST_READ;
                            if (chain) begin
                                sh <= busy ? {1'b0, code} : {code, 1'b0};
                                drive <= busy | ~next_cnv;
                                started <= 1'b1;
                            end else if (sel) begin
                                busy <= 1'b1;
                                sh <= {1'b0, code};
                                bits <= 5'h11;
                                drive <= 1'b1;
                                started <= 1'b1;
                            end else begin
                                busy <= 1'b0;
                                sh <= {code, 1'b0};
                                bits <= 5'h10;
                                started <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        state <= ST_ACQ;
                        drive <= 1'b0;
                    end
                endcase
            end
        end

        assign result_serial_output_o[ch] = sh[16];
        assign result_serial_oe_n_o[ch] = oe_n;
        assign status[ch * `STAT_CH_STRIDE + `STAT_CONVERTING] = state[1];
        assign status[ch * `STAT_CH_STRIDE + `STAT_READING] = state[2];
        assign status[ch * `STAT_CH_STRIDE + `STAT_CHAIN] = chain;
        assign status[ch * `STAT_CH_STRIDE + `STAT_BUSY_EN] = busy;
        assign status[ch * `STAT_CH_STRIDE + 7 : ch * `STAT_CH_STRIDE + 4] = 4'h0;
    end
endgenerate

endmodule

// ### verilog/dual_adc_serial_regs.vh
`ifndef DUAL_ADC_SERIAL_REGS_VH
`define DUAL_ADC_SERIAL_REGS_VH

// =====================================================
// register map, byte addresses on the bus
`define LEVEL0_ADDR 8'h00
`define LEVEL1_ADDR 8'h04
`define STATUS_ADDR 8'h08
`define LEVEL_RESET 18'h00000

// =====================================================
// status fields, one byte per converter at 8*channel
`define STAT_CH_STRIDE 8
`define STAT_CONVERTING 0
`define STAT_READING 1
`define STAT_CHAIN 2
`define STAT_BUSY_EN 3

// =====================================================
// coding and timing
`define RESULT_BITS 16
`define CODE_FULL 16'hffff
`define CODE_ZERO 16'h0000
`define CLK_PERIOD_NS 4
`define CONV_TIME_NS 500
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif
